/* hdl/pcpc_top.sv */
// parallel card port control: host strobes, byte lanes, ready/irq, ahb regs
// How it works
// - reset pin high holds port in reset
// - pin high from power-on: one reset only
// - soft reset bit resets the port
// - port reset leaves core logic running
// - odd select low uses upper lane
// - even select: lane from address zero, odd
// - memory mode: oe low drives read data
// - io mode: oe reads attribute space only
// - memory mode: write strobe stores data
// - io mode: write strobe for config only
// - memory mode: ready high, busy low
// - busy low until reset sequence ends
// - line held low at power-on: no busy
// - io mode: active-low irq, pulse or level
// - io read strobe in io mode only
// - io write latches on rising edge
// - 8-bit mode ignores upper lane
// - attribute select: high common, low attribute
`timescale 1ns/1ps
`default_nettype none
module pcpc_top
  import pcpc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic card_port_reset,
  input wire logic even_byte_select_n,
  input wire logic odd_byte_select_n,
  input wire logic output_enable_strobe_n,
  input wire logic write_strobe_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic attribute_space_select_n,
  input wire logic [3:0] port_addr,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic [1:0] data_oe,
  input wire logic ready_or_irq_in,
  output logic ready_or_irq_n,
  output logic ready_or_irq_oe,
  output logic port_in_reset
);
  import pcpc_pkg::*;

  // three-stage strobe and ready-line synchronisers, two-stage address and data; stage one feeds only stage two
  pcpc_strobes_t s1_reg, s2_reg, s3_reg, st_reg;
  logic [3:0] a1_reg, a2_reg;
  logic [15:0] d1_reg, d2_reg;
  logic l1_reg, l2_reg, l3_reg;
  pcpc_strobes_t raw;
  assign raw = '{card_port_reset, even_byte_select_n, odd_byte_select_n,
                 output_enable_strobe_n, write_strobe_n, io_read_strobe_n,
                 io_write_strobe_n, attribute_space_select_n};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      s2_reg <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      s3_reg <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      st_reg <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      a1_reg <= 4'h0;
      a2_reg <= 4'h0;
      d1_reg <= 16'h0000;
      d2_reg <= 16'h0000;
      l1_reg <= 1'b1;
      l2_reg <= 1'b1;
      l3_reg <= 1'b1;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // a change counts once stages two and three agree
      if (s2_reg == s3_reg) begin
        st_reg <= s3_reg;
      end
      a1_reg <= port_addr;
      a2_reg <= a1_reg;
      d1_reg <= data_in;
      d2_reg <= d1_reg;
      l1_reg <= ready_or_irq_in;
      l2_reg <= l1_reg;
      l3_reg <= l2_reg;
    end
  end

  // ahb slave: zero wait states, always okay
  logic [31:0] ctrl_reg;
  logic [7:0] wr_addr_reg;
  logic wr_pend_reg;
  logic irq_raise_reg, irq_clear_reg;
  logic take;
  assign take = hsel && hready && (htrans == PCPC_HTRANS_NONSEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= take && hwrite;
      if (take) begin
        wr_addr_reg <= haddr[7:0];
      end
    end
  end

  // soft reset bit self-clears once the port has taken it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= PCPC_CTRL_RESET;
      irq_raise_reg <= 1'b0;
      irq_clear_reg <= 1'b0;
    end else begin
      irq_raise_reg <= 1'b0;
      irq_clear_reg <= 1'b0;
      if (wr_pend_reg && wr_addr_reg == PCPC_CTRL_OFS) begin
        ctrl_reg <= {28'h0000000, hwdata[3:0]};
      end else if (ctrl_reg[PCPC_CTRL_SOFT_RST_BIT]) begin
        ctrl_reg[PCPC_CTRL_SOFT_RST_BIT] <= 1'b0;
      end
      if (wr_pend_reg && wr_addr_reg == PCPC_IRQ_OFS) begin
        irq_raise_reg <= hwdata[PCPC_IRQ_RAISE_BIT];
        irq_clear_reg <= hwdata[PCPC_IRQ_CLEAR_BIT];
      end
    end
  end

  logic io_mode, wide_mode, level_irq;
  assign io_mode = ctrl_reg[PCPC_CTRL_IO_MODE_BIT];
  assign wide_mode = ctrl_reg[PCPC_CTRL_WIDE_BIT];
  assign level_irq = ctrl_reg[PCPC_CTRL_LEVEL_IRQ_BIT];

  // power-on strap, taken once pin levels have filled the synchronisers;
  // earlier, the chain's reset values would pose as straps
  logic strap_done_reg, pin_strap_reg, rdy_strap_reg;
  logic [7:0] init_cnt_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done_reg <= 1'b0;
      pin_strap_reg <= 1'b0;
      rdy_strap_reg <= 1'b0;
    end else if (!strap_done_reg && s3_reg == s2_reg
                 && init_cnt_reg <= 8'(PCPC_INIT_CYC - PCPC_SYNC_STAGES)) begin
      strap_done_reg <= 1'b1;
      pin_strap_reg <= s3_reg.rst;
      rdy_strap_reg <= !l3_reg;
    end
  end

  // port reset; pin held high from power-on is ignored until it falls once
  logic pin_rst_reg, port_rst, strap_arm_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_rst_reg <= 1'b0;
    end else begin
      pin_rst_reg <= strap_done_reg && st_reg.rst
                     && !(pin_strap_reg && strap_arm_reg);
    end
  end
  // armed until the pin is first seen low after the strap was taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_arm_reg <= 1'b1;
    end else if (strap_done_reg && !st_reg.rst) begin
      strap_arm_reg <= 1'b0;
    end
  end
  assign port_rst = pin_rst_reg
                    || ctrl_reg[PCPC_CTRL_SOFT_RST_BIT];

  // reset sequence counter: busy until it runs out (power-on counts as one reset)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_cnt_reg <= 8'(PCPC_INIT_CYC);
    end else if (port_rst) begin
      init_cnt_reg <= 8'(PCPC_INIT_CYC);
    end else if (init_cnt_reg != 8'h00) begin
      init_cnt_reg <= init_cnt_reg - 8'h01;
    end
  end
  logic busy;
  assign busy = init_cnt_reg != 8'h00;

  // lane decode; only the port controller sees port_rst, core regs stay
  logic sel_any, odd_lane, even_lane, attr_space;
  assign sel_any = !(st_reg.even_n && st_reg.odd_n);
  assign attr_space = !st_reg.attr_n;
  always_comb begin
    odd_lane = !st_reg.odd_n && wide_mode;
    even_lane = 1'b0;
    if (!st_reg.even_n) begin
      if (!st_reg.odd_n && wide_mode) begin
        even_lane = 1'b1;
      end else if (a2_reg[0] && wide_mode) begin
        odd_lane = 1'b1;
      end else begin
        even_lane = 1'b1;
      end
    end
  end

  // port-side register files: common (data) and attribute (config)
  logic [15:0] port_regs [PCPC_NREGS];
  logic [15:0] cfg_regs [PCPC_NREGS];
  logic mem_wr, cfg_wr, io_wr;
  // trailing edge: settled strobe still low while stage three already high
  assign mem_wr = sel_any && !busy && st_reg.we_n == 1'b0 && s3_reg.we_n && !io_mode
                  && !attr_space;
  assign cfg_wr = sel_any && !busy && !st_reg.we_n && s3_reg.we_n && attr_space;
  assign io_wr = sel_any && !busy && io_mode && st_reg.iowr_n == 1'b0 && s3_reg.iowr_n;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < PCPC_NREGS; i++) begin
        port_regs[i] <= PCPC_DATA_RESET;
        cfg_regs[i] <= PCPC_DATA_RESET;
      end
    end else if (port_rst) begin
      for (int i = 0; i < PCPC_NREGS; i++) begin
        port_regs[i] <= PCPC_DATA_RESET;
        cfg_regs[i] <= PCPC_DATA_RESET;
      end
    end else begin
      if (mem_wr || io_wr) begin
        if (even_lane) port_regs[a2_reg][7:0] <= d2_reg[7:0];
        if (odd_lane) port_regs[a2_reg][15:8] <= even_lane ? d2_reg[15:8]
                                                : (wide_mode ? d2_reg[15:8] : d2_reg[7:0]);
      end
      if (cfg_wr) begin
        if (even_lane) cfg_regs[a2_reg][7:0] <= d2_reg[7:0];
        if (odd_lane) cfg_regs[a2_reg][15:8] <= d2_reg[15:8];
      end
    end
  end

  // read drive: oe in memory mode, oe on attribute or iord in io mode
  logic rd_on;
  assign rd_on = sel_any && !busy && ((!st_reg.oe_n && (!io_mode || attr_space))
                 || (!st_reg.iord_n && io_mode));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_out <= 16'h0000;
      data_oe <= 2'b00;
    end else begin
      data_out <= attr_space ? cfg_regs[a2_reg] : port_regs[a2_reg];
      data_oe <= rd_on ? {odd_lane, even_lane} : 2'b00;
    end
  end

  // ready/irq line: ready in memory mode, interrupt request in io mode
  logic irq_pend_reg;
  logic [7:0] pulse_cnt_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_pend_reg <= 1'b0;
      pulse_cnt_reg <= 8'h00;
    end else if (port_rst || !io_mode) begin
      irq_pend_reg <= 1'b0;
      pulse_cnt_reg <= 8'h00;
    end else begin
      // raise wins over clear in the same cycle
      if (irq_raise_reg) irq_pend_reg <= 1'b1;
      else if (irq_clear_reg) irq_pend_reg <= 1'b0;
      if (irq_raise_reg && !level_irq) pulse_cnt_reg <= 8'(PCPC_PULSE_CYC);
      else if (pulse_cnt_reg != 8'h00) pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_or_irq_n <= 1'b0;
      ready_or_irq_oe <= 1'b0;
      port_in_reset <= 1'b1;
    end else begin
      port_in_reset <= port_rst || busy;
      ready_or_irq_oe <= strap_done_reg && !(rdy_strap_reg && !io_mode);
      if (io_mode) begin
        ready_or_irq_n <= level_irq ? !irq_pend_reg : (pulse_cnt_reg == 8'h00);
      end else begin
        ready_or_irq_n <= !busy;
      end
    end
  end

  // ahb read data and response
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (take && !hwrite) begin
        case (haddr[7:0])
          PCPC_CTRL_OFS: hrdata <= ctrl_reg;
          PCPC_STAT_OFS: hrdata <= {28'h0000000, irq_pend_reg, busy, rdy_strap_reg,
                                   pin_strap_reg};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // checks
  property p_busy_low;
    @(posedge hclk) disable iff (!hresetn)
      (!io_mode && busy && !rdy_strap_reg) |=> !ready_or_irq_n;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("ready not low while busy");
  property p_soft_rst;
    @(posedge hclk) disable iff (!hresetn)
      ctrl_reg[PCPC_CTRL_SOFT_RST_BIT] |=> busy;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset missed");
  property p_desel;
    @(posedge hclk) disable iff (!hresetn)
      !sel_any |=> data_oe == 2'b00;
  endproperty
  a_desel: assert property (p_desel) else $error("driven while deselected");
  property p_iord_mem;
    @(posedge hclk) disable iff (!hresetn)
      (!io_mode && st_reg.oe_n) |=> data_oe == 2'b00;
  endproperty
  a_iord_mem: assert property (p_iord_mem) else $error("io read honoured in memory mode");
  property p_narrow;
    @(posedge hclk) disable iff (!hresetn)
      !wide_mode |=> !data_oe[1];
  endproperty
  a_narrow: assert property (p_narrow) else $error("upper lane driven in 8-bit mode");
  property p_ready;
    @(posedge hclk) disable iff (!hresetn)
      (!io_mode && !busy && !port_rst) |=> ready_or_irq_n;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not high when idle");
  property p_level;
    @(posedge hclk) disable iff (!hresetn)
      (io_mode && level_irq && irq_pend_reg) |=> !ready_or_irq_n;
  endproperty
  a_level: assert property (p_level) else $error("level irq not low");
  property p_pinrst;
    @(posedge hclk) disable iff (!hresetn)
      port_rst |=> init_cnt_reg == 8'(PCPC_INIT_CYC);
  endproperty
  a_pinrst: assert property (p_pinrst) else $error("port reset not restarting sequence");
  property p_strap;
    @(posedge hclk) disable iff (!hresetn)
      (pin_strap_reg && strap_arm_reg) |=> !pin_rst_reg;
  endproperty
  a_strap: assert property (p_strap) else $error("pin held from power-on still resets");
endmodule // pcpc_top
`default_nettype wire

/* hdl/pcpc_pkg.sv */
// shared constants and types for the parallel card port control block
package pcpc_pkg;
  // ahb register map (byte addresses)
  localparam logic [7:0] PCPC_CTRL_OFS = 8'h00;
  localparam logic [7:0] PCPC_STAT_OFS = 8'h04;
  localparam logic [7:0] PCPC_IRQ_OFS = 8'h08;
  // control register fields
  localparam int PCPC_CTRL_SOFT_RST_BIT = 0;
  localparam int PCPC_CTRL_IO_MODE_BIT = 1;
  localparam int PCPC_CTRL_LEVEL_IRQ_BIT = 2;
  localparam int PCPC_CTRL_WIDE_BIT = 3;
  localparam logic [31:0] PCPC_CTRL_RESET = 32'h0000_0000;
  // irq register: bit0 raises an interrupt event, bit1 clears a level request
  localparam int PCPC_IRQ_RAISE_BIT = 0;
  localparam int PCPC_IRQ_CLEAR_BIT = 1;
  // port-side register file
  localparam int PCPC_NREGS = 16;
  localparam logic [15:0] PCPC_DATA_RESET = 16'h0000;
  // timing: reset sequence length and interrupt pulse width
  localparam int PCPC_CLK_NS = 100;
  localparam int PCPC_INIT_NS = 2000;
  localparam int PCPC_INIT_CYC = (PCPC_INIT_NS + PCPC_CLK_NS - 1) / PCPC_CLK_NS;
  localparam int PCPC_PULSE_NS = 400;
  localparam int PCPC_PULSE_CYC = (PCPC_PULSE_NS + PCPC_CLK_NS - 1) / PCPC_CLK_NS;
  // synchroniser depth; the power-on strap waits until real pin levels fill it
  localparam int PCPC_SYNC_STAGES = 3;
  // synchronised host strobes travel together
  typedef struct packed {
    logic rst;
    logic even_n;
    logic odd_n;
    logic oe_n;
    logic we_n;
    logic iord_n;
    logic iowr_n;
    logic attr_n;
  } pcpc_strobes_t;
  typedef enum logic [1:0] {
    PCPC_HTRANS_IDLE = 2'b00,
    PCPC_HTRANS_BUSY = 2'b01,
    PCPC_HTRANS_NONSEQ = 2'b10,
    PCPC_HTRANS_SEQ = 2'b11
  } pcpc_htrans_t;
endpackage

/* sim/pcpc_host_model.sv */
// host controller model driving the parallel card port strobes
`timescale 1ns/1ps
`default_nettype none
module pcpc_host_model (
  input wire logic hclk,
  input wire logic ready_line,
  input wire logic [15:0] data_out,
  input wire logic [1:0] data_oe,
  output logic even_byte_select_n,
  output logic odd_byte_select_n,
  output logic output_enable_strobe_n,
  output logic write_strobe_n,
  output logic io_read_strobe_n,
  output logic io_write_strobe_n,
  output logic attribute_space_select_n,
  output logic [3:0] port_addr,
  output logic [15:0] data_in
);
  // idle bus: deselected, all strobes high
  initial begin
    {odd_byte_select_n, even_byte_select_n} = 2'b11;
    {io_write_strobe_n, io_read_strobe_n, write_strobe_n, output_enable_strobe_n} = 4'hf;
    attribute_space_select_n = 1'b1;
    port_addr = 4'h0;
    data_in = 16'h0000;
  end
  // one strobe cycle; kind 0 oe read, 1 we write, 2 io read, 3 io write
  task automatic access(input logic [1:0] kind, input logic [3:0] a, input logic [1:0] sel_n,
    input logic attr_n, input logic [15:0] wd, output logic [15:0] rd, output logic [1:0] oe);
    // wait up to 40 cycles while the card still reports busy
    for (int i = 0; i < 40 && ready_line !== 1'b1; i++) @(posedge hclk);
    @(posedge hclk);
    {odd_byte_select_n, even_byte_select_n} <= sel_n;
    attribute_space_select_n <= attr_n;
    port_addr <= a;
    data_in <= wd;
    repeat (2) @(posedge hclk);
    {io_write_strobe_n, io_read_strobe_n, write_strobe_n, output_enable_strobe_n} <=
      ~(4'h1 << kind);
    // long enough to cross the sync chain and answer
    repeat (8) @(posedge hclk);
    rd = data_out;
    oe = data_oe;
    {io_write_strobe_n, io_read_strobe_n, write_strobe_n, output_enable_strobe_n} <= 4'hf;
    // address and data held past the trailing edge while it crosses over
    repeat (6) @(posedge hclk);
    {odd_byte_select_n, even_byte_select_n} <= 2'b11;
    attribute_space_select_n <= 1'b1;
    // released bus shows the inverse, never a stale copy
    data_in <= ~wd;
    @(posedge hclk);
  endtask
endmodule // pcpc_host_model
`default_nettype wire

/* sim/tb_parallel_card_port_control.sv */
// self-checking bench for the parallel card port control block
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_card_port_control;
  import pcpc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = PCPC_HTRANS_IDLE;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, card_port_reset = 1'b1;
  logic even_n, odd_n, oe_n, we_n, iord_n, iowr_n, attr_n;
  logic [3:0] port_addr;
  logic [15:0] data_in, data_out, rd;
  logic [1:0] data_oe, oe;
  logic ready_or_irq_n, ready_or_irq_oe, port_in_reset, ready_line;
  logic hold_low = 1'b0;
  logic [31:0] r;
  int errors = 0;
  int checks = 0;
  int n;
  // clock at 10 MHz
  always #50 hclk = ~hclk;
  // line pulled up whenever the card lets go of it; the host may hold it low
  assign ready_line = hold_low ? 1'b0 : (ready_or_irq_oe ? ready_or_irq_n : 1'b1);
  pcpc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .card_port_reset(card_port_reset),
    .even_byte_select_n(even_n), .odd_byte_select_n(odd_n), .output_enable_strobe_n(oe_n),
    .write_strobe_n(we_n), .io_read_strobe_n(iord_n), .io_write_strobe_n(iowr_n),
    .attribute_space_select_n(attr_n), .port_addr(port_addr), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .ready_or_irq_in(ready_line),
    .ready_or_irq_n(ready_or_irq_n), .ready_or_irq_oe(ready_or_irq_oe),
    .port_in_reset(port_in_reset));
  pcpc_host_model host (.hclk(hclk), .ready_line(ready_line), .data_out(data_out),
    .data_oe(data_oe), .even_byte_select_n(even_n), .odd_byte_select_n(odd_n),
    .output_enable_strobe_n(oe_n), .write_strobe_n(we_n), .io_read_strobe_n(iord_n),
    .io_write_strobe_n(iowr_n), .attribute_space_select_n(attr_n), .port_addr(port_addr),
    .data_in(data_in));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one single ahb-lite word transfer, waiting on hready in both phases
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rdat);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= PCPC_HTRANS_NONSEQ;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= PCPC_HTRANS_IDLE;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdat = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic t_power();
    // the card drives the line only once its strap has been taken
    repeat (6) @(posedge hclk);
    chk("busy after release", 32'h1, {31'h0, port_in_reset});
    chk("ready line busy", 32'h0, {31'h0, ready_line});
    repeat (PCPC_INIT_CYC + 5) @(posedge hclk);
    chk("pin high from power-on", 32'h0, {31'h0, port_in_reset});
    chk("ready line ready", 32'h1, {31'h0, ready_or_irq_n & ready_or_irq_oe});
    ahb(1'b0, PCPC_CTRL_OFS, 32'h0, r);
    chk("ctrl reset", PCPC_CTRL_RESET, r);
    ahb(1'b0, 8'h0c, 32'h0, r);
    chk("unmapped read", 32'h0, r);
    card_port_reset <= 1'b0;
  endtask
  task automatic t_mem();
    ahb(1'b1, PCPC_CTRL_OFS, 32'h8, r);
    host.access(2'd1, 4'h2, 2'b00, 1'b1, 16'h5aa5, rd, oe);
    host.access(2'd0, 4'h2, 2'b00, 1'b1, 16'h0000, rd, oe);
    chk("word read", 32'h5aa5, {16'h0, rd});
    chk("word lanes", 32'h3, {30'h0, oe});
    host.access(2'd0, 4'h2, 2'b01, 1'b1, 16'h0000, rd, oe);
    chk("odd lane", 32'h2, {30'h0, oe});
    chk("odd byte", 32'h5a, {24'h0, rd[15:8]});
    host.access(2'd0, 4'h3, 2'b10, 1'b1, 16'h0000, rd, oe);
    chk("even select odd address lane", 32'h2, {30'h0, oe});
    host.access(2'd0, 4'h2, 2'b10, 1'b1, 16'h0000, rd, oe);
    chk("even select even address lane", 32'h1, {30'h0, oe});
    chk("even byte", 32'ha5, {24'h0, rd[7:0]});
    host.access(2'd0, 4'h2, 2'b11, 1'b1, 16'h0000, rd, oe);
    chk("deselected", 32'h0, {30'h0, oe});
    host.access(2'd2, 4'h2, 2'b00, 1'b1, 16'h0000, rd, oe);
    chk("io read in memory mode", 32'h0, {30'h0, oe});
    ahb(1'b1, PCPC_CTRL_OFS, 32'h0, r);
    host.access(2'd1, 4'h4, 2'b00, 1'b1, 16'hffc3, rd, oe);
    host.access(2'd0, 4'h4, 2'b00, 1'b1, 16'h0000, rd, oe);
    chk("narrow upper lane", 32'h0, {31'h0, oe[1]});
    chk("narrow byte", 32'hc3, {24'h0, rd[7:0]});
  endtask
  task automatic t_io();
    ahb(1'b1, PCPC_CTRL_OFS, 32'ha, r);
    host.access(2'd2, 4'h2, 2'b00, 1'b1, 16'h0000, rd, oe);
    chk("io read", 32'h5aa5, {16'h0, rd});
    host.access(2'd0, 4'h2, 2'b00, 1'b1, 16'h0000, rd, oe);
    chk("oe on common space in io mode", 32'h0, {30'h0, oe});
    host.access(2'd1, 4'h2, 2'b00, 1'b1, 16'h1234, rd, oe);
    host.access(2'd2, 4'h2, 2'b00, 1'b1, 16'h0000, rd, oe);
    chk("we ignored in io mode", 32'h5aa5, {16'h0, rd});
    host.access(2'd3, 4'h2, 2'b00, 1'b1, 16'h0f0f, rd, oe);
    host.access(2'd2, 4'h2, 2'b00, 1'b1, 16'h0000, rd, oe);
    chk("io write", 32'h0f0f, {16'h0, rd});
    host.access(2'd1, 4'h5, 2'b00, 1'b0, 16'h3c96, rd, oe);
    host.access(2'd0, 4'h5, 2'b00, 1'b0, 16'h0000, rd, oe);
    chk("config write in io mode", 32'h3c96, {16'h0, rd});
    chk("config read lanes in io mode", 32'h3, {30'h0, oe});
  endtask
  task automatic t_irq();
    ahb(1'b1, PCPC_IRQ_OFS, 32'h1, r);
    n = 0;
    // count the low cycles of one pulse
    repeat (20) begin
      @(posedge hclk);
      if (ready_line === 1'b0) n++;
    end
    chk("pulse width", PCPC_PULSE_CYC, n);
    ahb(1'b1, PCPC_CTRL_OFS, 32'he, r);
    // the pulse-mode event left a request pending; clear it first
    ahb(1'b1, PCPC_IRQ_OFS, 32'h2, r);
    repeat (3) @(posedge hclk);
    chk("level idle", 32'h1, {31'h0, ready_line});
    ahb(1'b1, PCPC_IRQ_OFS, 32'h1, r);
    repeat (10) @(posedge hclk);
    chk("level held", 32'h0, {31'h0, ready_line});
    ahb(1'b1, PCPC_IRQ_OFS, 32'h2, r);
    repeat (3) @(posedge hclk);
    chk("level cleared", 32'h1, {31'h0, ready_line});
  endtask
  task automatic t_reset();
    ahb(1'b1, PCPC_CTRL_OFS, 32'hb, r);
    repeat (2) @(posedge hclk);
    chk("soft reset", 32'h1, {31'h0, port_in_reset});
    ahb(1'b0, PCPC_CTRL_OFS, 32'h0, r);
    chk("core regs kept", 32'ha, r);
    repeat (PCPC_INIT_CYC + 5) @(posedge hclk);
    chk("soft reset ends", 32'h0, {31'h0, port_in_reset});
    card_port_reset <= 1'b1;
    repeat (PCPC_INIT_CYC + 10) @(posedge hclk);
    chk("pin reset held", 32'h1, {31'h0, port_in_reset});
    ahb(1'b0, PCPC_STAT_OFS, 32'h0, r);
    chk("busy while pin high", 32'h1, {31'h0, r[2]});
    card_port_reset <= 1'b0;
    // pin crosses the synchroniser before the sequence restarts
    repeat (PCPC_INIT_CYC + 10) @(posedge hclk);
    chk("pin reset ends", 32'h0, {31'h0, port_in_reset});
  endtask
  // second power-up with the host holding the ready line low throughout
  task automatic t_strap();
    @(posedge hclk);
    hresetn <= 1'b0;
    hold_low <= 1'b1;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (PCPC_INIT_CYC + 10) @(posedge hclk);
    chk("ready line left undriven", 32'h0, {31'h0, ready_or_irq_oe});
    chk("busy ends with line held", 32'h0, {31'h0, port_in_reset});
    ahb(1'b0, PCPC_STAT_OFS, 32'h0, r);
    chk("straps seen", 32'h2, {30'h0, r[1:0]});
    hold_low <= 1'b0;
  endtask
  task automatic final_report();
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_power();
    t_mem();
    t_io();
    t_irq();
    t_reset();
    t_strap();
    final_report();
  end
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    #2000000;
    errors++;
    final_report();
  end
endmodule // tb_parallel_card_port_control
`default_nettype wire
